// File: core/mpp_top.sv
// Three-port pin control with AHB-Lite register access.
// Assumes a single AHB-Lite master, word transfers, pads resolved outside.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/100ps
module mpp_top (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// First port pads
	input wire logic [5:0] pb_pin_in,
	output logic [5:0] pb_pin_out,
	output logic [5:0] pb_oe_n,
	output logic [5:0] pb_pullup,
	// Second port pads
	input wire logic [5:0] pc_pin_in,
	output logic [5:0] pc_pin_out,
	output logic [5:0] pc_oe_n,
	output logic [5:0] pc_pullup,
	// Third port pads
	input wire logic [7:0] pd_pin_in,
	output logic [7:0] pd_pin_out,
	output logic [7:0] pd_oe_n,
	output logic [7:0] pd_pullup,
	// Peripheral controls
	input wire logic spi_enable,
	input wire logic spi_master,
	input wire logic spi_sck_out,
	input wire logic spi_mosi_out,
	input wire logic spi_miso_out,
	input wire logic compare_out_en,
	input wire logic compare_match_out,
	input wire logic uart_tx_en,
	input wire logic uart_txd,
	input wire logic uart_rx_en,
	input wire logic power_down,
	// Synchronised pin inputs to peripherals
	output logic capture_trigger_in,
	output logic spi_ss_n_in,
	output logic spi_sck_in,
	output logic spi_mosi_in,
	output logic spi_miso_in,
	output logic uart_rxd_in,
	output logic ext_irq_zero_in,
	output logic ext_irq_one_in,
	output logic counter_zero_clk_in,
	output logic counter_one_clk_in
);

	mpp_pkg::mpp_bus_t state;
	mpp_pkg::mpp_bus_t next_state;
	logic [7:0] addr_q;
	logic hi_ok;
	logic [5:0] b_dir;
	logic [5:0] b_latch;
	logic [5:0] c_dir;
	logic [5:0] c_latch;
	logic [7:0] d_dir;
	logic [7:0] d_latch;
	logic [5:0] pb_sync;
	logic [5:0] pc_sync;
	logic [7:0] pd_sync;
	logic [5:0] pc_level;
	logic [7:0] pd_level;
	logic [31:0] rd_val;

	// Bus decode
	wire take = hsel & htrans[1] & hready;
	wire [5:0] idx = addr_q[7:2];
	wire hit = hi_ok & (addr_q[1:0] == 2'h0);
	wire wr_en = (state == mpp_pkg::MPP_WR) & hit;
	// no write strobe for pin-level addresses
	wire wr_b_dir = wr_en & (idx == mpp_pkg::IDX_B_DIR);
	wire wr_b_latch = wr_en & (idx == mpp_pkg::IDX_B_LATCH);
	wire wr_c_dir = wr_en & (idx == mpp_pkg::IDX_C_DIR);
	wire wr_c_latch = wr_en & (idx == mpp_pkg::IDX_C_LATCH);
	wire wr_d_dir = wr_en & (idx == mpp_pkg::IDX_D_DIR);
	wire wr_d_latch = wr_en & (idx == mpp_pkg::IDX_D_LATCH);

	// One wait state on reads so a preceding write is always seen
	assign hreadyout = (state != mpp_pkg::MPP_RD_WAIT);
	assign hresp = 1'b0;

	always_comb begin
		next_state = state;
		case (state)
			mpp_pkg::MPP_RD_WAIT: next_state = mpp_pkg::MPP_RD;
			mpp_pkg::MPP_IDLE, mpp_pkg::MPP_WR, mpp_pkg::MPP_RD: begin
				if (take)
					next_state = hwrite ? mpp_pkg::MPP_WR : mpp_pkg::MPP_RD_WAIT;
				else
					next_state = mpp_pkg::MPP_IDLE;
			end
			default: next_state = mpp_pkg::MPP_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			state <= mpp_pkg::MPP_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q <= 8'h00;
			hi_ok <= 1'b0;
		end else if (take) begin
			addr_q <= haddr[7:0];
			hi_ok <= (haddr[31:8] == 24'h000000);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			b_dir <= mpp_pkg::SMALL_RST;
			b_latch <= mpp_pkg::SMALL_RST;
		end else begin
			if (wr_b_dir)
				b_dir <= hwdata[5:0];
			if (wr_b_latch)
				b_latch <= hwdata[5:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			c_dir <= mpp_pkg::SMALL_RST;
			c_latch <= mpp_pkg::SMALL_RST;
		end else begin
			if (wr_c_dir)
				c_dir <= hwdata[5:0];
			if (wr_c_latch)
				c_latch <= hwdata[5:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			d_dir <= mpp_pkg::WIDE_RST;
			d_latch <= mpp_pkg::WIDE_RST;
		end else begin
			if (wr_d_dir)
				d_dir <= hwdata[7:0];
			if (wr_d_latch)
				d_latch <= hwdata[7:0];
		end
	end

	assign rd_val = !hit ? 32'h00000000 :
		(idx == mpp_pkg::IDX_B_PIN) ? {26'h0000000, pb_sync} :
		(idx == mpp_pkg::IDX_B_DIR) ? {26'h0000000, b_dir} :
		(idx == mpp_pkg::IDX_B_LATCH) ? {26'h0000000, b_latch} :
		(idx == mpp_pkg::IDX_C_PIN) ? {26'h0000000, pc_level} :
		(idx == mpp_pkg::IDX_C_DIR) ? {26'h0000000, c_dir} :
		(idx == mpp_pkg::IDX_C_LATCH) ? {26'h0000000, c_latch} :
		(idx == mpp_pkg::IDX_D_PIN) ? {24'h000000, pd_level} :
		(idx == mpp_pkg::IDX_D_DIR) ? {24'h000000, d_dir} :
		(idx == mpp_pkg::IDX_D_LATCH) ? {24'h000000, d_latch} :
		32'h00000000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= mpp_pkg::RDATA_RST;
		else if (state == mpp_pkg::MPP_RD_WAIT)
			hrdata <= rd_val;
	end

	mpp_sync #(.W(mpp_pkg::SMALL_W)) u_sync_b (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in(pb_pin_in),
		.sync_out(pb_sync)
	);

	mpp_sync #(.W(mpp_pkg::SMALL_W)) u_sync_c (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in(pc_pin_in),
		.sync_out(pc_sync)
	);

	mpp_sync #(.W(mpp_pkg::WIDE_W)) u_sync_d (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in(pd_pin_in),
		.sync_out(pd_sync)
	);

	assign pc_level = pc_sync & ~{6{power_down}};
	// Comparator pins also carry analog levels, so they are cut too
	assign pd_level[5:0] = pd_sync[5:0];
	assign pd_level[mpp_pkg::CMP_POS_BIT] = pd_sync[mpp_pkg::CMP_POS_BIT] & ~power_down;
	assign pd_level[mpp_pkg::CMP_NEG_BIT] = pd_sync[mpp_pkg::CMP_NEG_BIT] & ~power_down;

	// First port overrides
	wire spi_slave = spi_enable & ~spi_master;
	wire spi_mst = spi_enable & spi_master;
	wire [5:0] b_force_in;
	wire [5:0] b_alt_sel;
	wire [5:0] b_alt_val;

	assign b_force_in[mpp_pkg::SCK_BIT] = spi_slave;
	assign b_force_in[mpp_pkg::MISO_BIT] = spi_mst;
	assign b_force_in[mpp_pkg::MOSI_BIT] = spi_slave;
	assign b_force_in[mpp_pkg::SS_BIT] = spi_slave;
	assign b_force_in[mpp_pkg::OC_BIT] = 1'b0;
	assign b_force_in[mpp_pkg::CAPT_BIT] = 1'b0;

	assign b_alt_sel[mpp_pkg::SCK_BIT] = spi_mst;
	assign b_alt_sel[mpp_pkg::MISO_BIT] = spi_slave;
	assign b_alt_sel[mpp_pkg::MOSI_BIT] = spi_mst;
	assign b_alt_sel[mpp_pkg::SS_BIT] = 1'b0;
	assign b_alt_sel[mpp_pkg::OC_BIT] = compare_out_en;
	assign b_alt_sel[mpp_pkg::CAPT_BIT] = 1'b0;

	assign b_alt_val[mpp_pkg::SCK_BIT] = spi_sck_out;
	assign b_alt_val[mpp_pkg::MISO_BIT] = spi_miso_out;
	assign b_alt_val[mpp_pkg::MOSI_BIT] = spi_mosi_out;
	assign b_alt_val[mpp_pkg::SS_BIT] = 1'b0;
	assign b_alt_val[mpp_pkg::OC_BIT] = compare_match_out;
	assign b_alt_val[mpp_pkg::CAPT_BIT] = 1'b0;

	// Wide port overrides
	wire [7:0] d_force_in;
	wire [7:0] d_force_out;
	wire [7:0] d_alt_sel;

	assign d_force_in = {7'h00, uart_rx_en};
	assign d_force_out = {6'h00, uart_tx_en, 1'b0};
	assign d_alt_sel = {6'h00, uart_tx_en, 1'b0};

	// pull-up kept by latch under force
	mpp_pin_cell #(.W(mpp_pkg::SMALL_W)) u_cell_b (
		.resetn(hresetn),
		.dir(b_dir),
		.latch(b_latch),
		.force_in(b_force_in),
		.force_out(6'h00),
		.alt_sel(b_alt_sel),
		.alt_val(b_alt_val),
		.pad_out(pb_pin_out),
		.pad_oe_n(pb_oe_n),
		.pullup_en(pb_pullup)
	);

	// outputs move only on software writes and reset
	mpp_pin_cell #(.W(mpp_pkg::SMALL_W)) u_cell_c (
		.resetn(hresetn),
		.dir(c_dir),
		.latch(c_latch),
		.force_in(6'h00),
		.force_out(6'h00),
		.alt_sel(6'h00),
		.alt_val(6'h00),
		.pad_out(pc_pin_out),
		.pad_oe_n(pc_oe_n),
		.pullup_en(pc_pullup)
	);

	mpp_pin_cell #(.W(mpp_pkg::WIDE_W)) u_cell_d (
		.resetn(hresetn),
		.dir(d_dir),
		.latch(d_latch),
		.force_in(d_force_in),
		.force_out(d_force_out),
		.alt_sel(d_alt_sel),
		.alt_val({6'h00, uart_txd, 1'b0}),
		.pad_out(pd_pin_out),
		.pad_oe_n(pd_oe_n),
		.pullup_en(pd_pullup)
	);

	// capture, SPI, UART, interrupt and counter inputs from synchronised levels
	assign capture_trigger_in = pb_sync[mpp_pkg::CAPT_BIT];
	assign spi_ss_n_in = pb_sync[mpp_pkg::SS_BIT];
	assign spi_sck_in = pb_sync[mpp_pkg::SCK_BIT];
	assign spi_mosi_in = pb_sync[mpp_pkg::MOSI_BIT];
	assign spi_miso_in = pb_sync[mpp_pkg::MISO_BIT];
	assign uart_rxd_in = pd_sync[mpp_pkg::RXD_BIT];
	assign ext_irq_zero_in = pd_sync[mpp_pkg::IRQ0_BIT];
	assign ext_irq_one_in = pd_sync[mpp_pkg::IRQ1_BIT];
	assign counter_zero_clk_in = pd_sync[mpp_pkg::CNT0_BIT];
	assign counter_one_clk_in = pd_sync[mpp_pkg::CNT1_BIT];

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	dir_drive_a: assert property (d_dir[7] |-> !pd_oe_n[7] && pd_pin_out[7] == d_latch[7])
		else $error("direction one does not drive latch");

	// pull-up only as input with latch set
	pullup_sel_a: assert property (pc_pullup[0] == (!c_dir[0] && c_latch[0]))
		else $error("pull-up disagrees with direction and latch");

	reset_float_a: assert property (@(posedge hclk) disable iff (1'b0)
		!hresetn |-> &pb_oe_n && &pc_oe_n && &pd_oe_n && pd_pullup == 8'h00
		&& pb_pullup == 6'h00 && pc_pullup == 6'h00)
		else $error("pin driven during reset");

	latch_read_a: assert property (state == mpp_pkg::MPP_RD_WAIT && hit && idx == mpp_pkg::IDX_D_LATCH
		|=> hreadyout && hrdata == {24'h000000, $past(d_latch)})
		else $error("latch read wrong");

	ro_write_a: assert property (wr_en && (idx == mpp_pkg::IDX_B_PIN || idx == mpp_pkg::IDX_C_PIN
		|| idx == mpp_pkg::IDX_D_PIN) |=> $stable(b_dir) && $stable(b_latch) && $stable(c_dir)
		&& $stable(c_latch) && $stable(d_dir) && $stable(d_latch))
		else $error("write to pin-level address took effect");

	upper_zero_a: assert property (state == mpp_pkg::MPP_RD && hi_ok && idx[5:2] == 4'h5
		|-> hrdata[31:6] == 26'h0000000)
		else $error("upper bits of six-pin port not zero");

	sck_slave_a: assert property (spi_slave |-> pb_oe_n[mpp_pkg::SCK_BIT])
		else $error("clock pin driven as slave");

	miso_master_a: assert property (spi_mst |-> pb_oe_n[mpp_pkg::MISO_BIT])
		else $error("data-in pin driven as master");

	ss_slave_a: assert property (spi_slave |-> pb_oe_n[mpp_pkg::SS_BIT])
		else $error("select pin driven as slave");

	forced_pullup_a: assert property (spi_slave && b_latch[mpp_pkg::MOSI_BIT]
		|-> pb_pullup[mpp_pkg::MOSI_BIT])
		else $error("forced input lost its pull-up");

	pd_isolate_a: assert property (power_down && state == mpp_pkg::MPP_RD_WAIT && hit
		&& idx == mpp_pkg::IDX_C_PIN |=> hrdata == 32'h00000000)
		else $error("analog port read nonzero in power-down");

	sync_delay_a: assert property ($past(hresetn, 2) |-> pb_sync == $past(pb_pin_in, 2))
		else $error("synchroniser delay is not two cycles");

	tx_force_a: assert property (uart_tx_en |-> !pd_oe_n[mpp_pkg::TXD_BIT]
		&& pd_pin_out[mpp_pkg::TXD_BIT] == uart_txd)
		else $error("transmit pin not driven");

	rx_force_a: assert property (uart_rx_en |-> pd_oe_n[mpp_pkg::RXD_BIT]
		&& pd_pullup[mpp_pkg::RXD_BIT] == d_latch[mpp_pkg::RXD_BIT])
		else $error("receive pin not an input");

	// Read answer always within two cycles
	read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

endmodule // mpp_top

// File: common/mpp_pkg.sv
// Constants and types shared by the multi-port pin control block.
// Assumes a 32-bit AHB-Lite bus with word-aligned registers.
package mpp_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_D_PIN = 6'h10;
	localparam logic [5:0] IDX_D_DIR = 6'h11;
	localparam logic [5:0] IDX_D_LATCH = 6'h12;
	localparam logic [5:0] IDX_C_PIN = 6'h13;
	localparam logic [5:0] IDX_C_DIR = 6'h14;
	localparam logic [5:0] IDX_C_LATCH = 6'h15;
	localparam logic [5:0] IDX_B_PIN = 6'h16;
	localparam logic [5:0] IDX_B_DIR = 6'h17;
	localparam logic [5:0] IDX_B_LATCH = 6'h18;

	// Port widths
	localparam int SMALL_W = 6;
	localparam int WIDE_W = 8;

	// Values after reset
	localparam logic [5:0] SMALL_RST = 6'h00;
	localparam logic [7:0] WIDE_RST = 8'h00;
	localparam logic [31:0] RDATA_RST = 32'h00000000;

	// First port alternate pins
	localparam int SCK_BIT = 5;
	localparam int MISO_BIT = 4;
	localparam int MOSI_BIT = 3;
	localparam int SS_BIT = 2;
	localparam int OC_BIT = 1;
	localparam int CAPT_BIT = 0;

	// Wide port alternate pins
	localparam int RXD_BIT = 0;
	localparam int TXD_BIT = 1;
	localparam int IRQ0_BIT = 2;
	localparam int IRQ1_BIT = 3;
	localparam int CNT0_BIT = 4;
	localparam int CNT1_BIT = 5;
	localparam int CMP_POS_BIT = 6;
	localparam int CMP_NEG_BIT = 7;

	// Synchroniser depth in cycles
	localparam int SYNC_STAGES = 2;

	// Bus data-phase states
	typedef enum logic [1:0] {
		MPP_IDLE,
		MPP_WR,
		MPP_RD_WAIT,
		MPP_RD
	} mpp_bus_t;

endpackage

// File: core/mpp_sync.sv
// Two-flop synchroniser for a vector of pin inputs.
// Assumes inputs are asynchronous to hclk.
`timescale 1ns/100ps
module mpp_sync #(
	parameter int W = 6
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Data
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] meta;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta <= '0;
			sync_out <= '0;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule // mpp_sync

// File: core/mpp_pin_cell.sv
// Pad control for one port: direction, drive value and pull-up.
// Assumes direction and latch come from flops; reset gating is async.
`timescale 1ns/100ps
module mpp_pin_cell #(
	parameter int W = 6
) (
	// Reset
	input wire logic resetn,
	// Software settings
	input wire logic [W-1:0] dir,
	input wire logic [W-1:0] latch,
	// Alternate function overrides
	input wire logic [W-1:0] force_in,
	input wire logic [W-1:0] force_out,
	input wire logic [W-1:0] alt_sel,
	input wire logic [W-1:0] alt_val,
	// Pads
	output logic [W-1:0] pad_out,
	output logic [W-1:0] pad_oe_n,
	output logic [W-1:0] pullup_en
);

	wire [W-1:0] eff_dir;

	assign eff_dir = (dir | force_out) & ~force_in;
	assign pad_out = (alt_sel & alt_val) | (~alt_sel & latch);
	assign pad_oe_n = ~(eff_dir & {W{resetn}});
	assign pullup_en = ~eff_dir & latch & {W{resetn}};

endmodule // mpp_pin_cell

// File: tb/mpp_board.sv
// Board model for one port: resolves each pad from device drive, pull-up and external drivers.
// Assumes oe_n low means the device drives; an undriven pad without pull-up toggles every cycle.
`timescale 1ns/100ps
module mpp_board #(
	parameter int W = 6
) (
	// Clock
	input wire logic hclk,
	// Device side
	input wire logic [W-1:0] oe_n,
	input wire logic [W-1:0] pin_out,
	input wire logic [W-1:0] pull_en,
	// External drivers
	input wire logic [W-1:0] ext_en,
	input wire logic [W-1:0] ext_val,
	// Resolved pads
	output logic [W-1:0] pin_in
);
	logic [W-1:0] float_pat;
	initial float_pat = '0;
	// Floating pads must never look stable
	always @(posedge hclk) float_pat <= ~float_pat;
	assign pin_in = (~oe_n & pin_out) | (oe_n & ext_en & ext_val) | (oe_n & ~ext_en & (pull_en | float_pat));
endmodule // mpp_board

// File: tb/test_multi_port_pin_control.sv
// Self-checking bench for the three-port pin block over AHB-Lite.
// Assumes the board model resolves pads; bus master is single word transfers.
`timescale 1ns/100ps
module test_multi_port_pin_control;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic [5:0] pb_in, pb_out, pb_oe_n, pb_pu, pb_xe, pb_xv, pc_in, pc_out, pc_oe_n, pc_pu;
	logic [7:0] pd_in, pd_out, pd_oe_n, pd_pu, pd_xe, pd_xv;
	logic spi_en, spi_mst, sck_o, mosi_o, miso_o, cmp_en, cmp_o, tx_en, txd, rx_en, pdown;
	logic cap_i, ss_n_i, sck_i, mosi_i, miso_i, rxd_i, irq0_i, irq1_i, cnt0_i, cnt1_i;
	int miscompares, cmp_count;

	mpp_top mpp_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .pb_pin_in(pb_in), .pb_pin_out(pb_out), .pb_oe_n(pb_oe_n),
		.pb_pullup(pb_pu), .pc_pin_in(pc_in), .pc_pin_out(pc_out), .pc_oe_n(pc_oe_n), .pc_pullup(pc_pu),
		.pd_pin_in(pd_in), .pd_pin_out(pd_out), .pd_oe_n(pd_oe_n), .pd_pullup(pd_pu), .spi_enable(spi_en),
		.spi_master(spi_mst), .spi_sck_out(sck_o), .spi_mosi_out(mosi_o), .spi_miso_out(miso_o),
		.compare_out_en(cmp_en), .compare_match_out(cmp_o), .uart_tx_en(tx_en), .uart_txd(txd),
		.uart_rx_en(rx_en), .power_down(pdown), .capture_trigger_in(cap_i), .spi_ss_n_in(ss_n_i),
		.spi_sck_in(sck_i), .spi_mosi_in(mosi_i), .spi_miso_in(miso_i), .uart_rxd_in(rxd_i),
		.ext_irq_zero_in(irq0_i), .ext_irq_one_in(irq1_i), .counter_zero_clk_in(cnt0_i),
		.counter_one_clk_in(cnt1_i));
	mpp_board #(.W(6)) board_b (.hclk(hclk), .oe_n(pb_oe_n), .pin_out(pb_out), .pull_en(pb_pu),
		.ext_en(pb_xe), .ext_val(pb_xv), .pin_in(pb_in));
	mpp_board #(.W(6)) board_c (.hclk(hclk), .oe_n(pc_oe_n), .pin_out(pc_out), .pull_en(pc_pu),
		.ext_en(6'h00), .ext_val(6'h00), .pin_in(pc_in));
	mpp_board #(.W(8)) board_d (.hclk(hclk), .oe_n(pd_oe_n), .pin_out(pd_out), .pull_en(pd_pu),
		.ext_en(pd_xe), .ext_val(pd_xv), .pin_in(pd_in));

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask

	// Address phase held until hready, then data phase held until hready
	task automatic ahb(input logic w, input logic [5:0] idx, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, idx, 2'b00};
		hwrite <= w;
		htrans <= 2'b10;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
		#1;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, idx, d, x);
	endtask

	task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
		logic [31:0] x;
		ahb(1'b0, idx, 32'h00000000, x);
		chk(x, exp);
		chk(32'(hresp), 32'h00000000);
	endtask

	task automatic t_regs_zero();
		rdc(mpp_pkg::IDX_B_DIR, 32'h00000000);
		rdc(mpp_pkg::IDX_B_LATCH, 32'h00000000);
		rdc(mpp_pkg::IDX_C_DIR, 32'h00000000);
		rdc(mpp_pkg::IDX_C_LATCH, 32'h00000000);
		rdc(mpp_pkg::IDX_D_DIR, 32'h00000000);
		rdc(mpp_pkg::IDX_D_LATCH, 32'h00000000);
		chk(32'({pb_oe_n, pc_oe_n, pd_oe_n}), 32'h000FFFFF);
	endtask

	task automatic t_gpio();
		wr(mpp_pkg::IDX_D_DIR, 32'h0000000F);
		wr(mpp_pkg::IDX_D_LATCH, 32'h00000033);
		chk(32'(pd_oe_n), 32'h000000F0);
		chk(32'(pd_out[3:0]), 32'h00000003);
		chk(32'(pd_pu), 32'h00000030);
		rdc(mpp_pkg::IDX_D_LATCH, 32'h00000033);
		@(posedge hclk);
		pd_xe <= 8'hC0;
		pd_xv <= 8'h40;
		rdc(mpp_pkg::IDX_D_PIN, 32'h00000073);
		chk(32'({cnt1_i, cnt0_i, irq1_i, irq0_i}), 32'h0000000C);
		@(posedge hclk);
		pd_xe <= 8'hD0;
		tick(1);
		chk(32'(cnt0_i), 32'h00000001);
		tick(1);
		chk(32'(cnt0_i), 32'h00000000);
		wr(mpp_pkg::IDX_D_PIN, 32'h000000FF);
		rdc(mpp_pkg::IDX_D_LATCH, 32'h00000033);
		rdc(mpp_pkg::IDX_D_DIR, 32'h0000000F);
		wr(6'h1F, 32'h000000FF);
		rdc(6'h1F, 32'h00000000);
		wr(mpp_pkg::IDX_D_DIR, 32'h000000FF);
		chk(32'(pd_pu), 32'h00000000);
		pd_xe <= 8'h00;
	endtask

	task automatic t_narrow();
		wr(mpp_pkg::IDX_B_DIR, 32'h000000FF);
		rdc(mpp_pkg::IDX_B_DIR, 32'h0000003F);
		wr(mpp_pkg::IDX_B_PIN, 32'h00000000);
		rdc(mpp_pkg::IDX_B_DIR, 32'h0000003F);
		chk(32'(pb_oe_n), 32'h00000000);
		wr(mpp_pkg::IDX_C_LATCH, 32'h000000FF);
		rdc(mpp_pkg::IDX_C_LATCH, 32'h0000003F);
		chk(32'(pc_pu), 32'h0000003F);
		rdc(mpp_pkg::IDX_C_PIN, 32'h0000003F);
		@(posedge hclk);
		pdown <= 1'b1;
		rdc(mpp_pkg::IDX_C_PIN, 32'h00000000);
		@(posedge hclk);
		pdown <= 1'b0;
	endtask

	task automatic t_spi();
		wr(mpp_pkg::IDX_B_LATCH, 32'h0000003F);
		@(posedge hclk);
		spi_en <= 1'b1;
		miso_o <= 1'b0;
		tick(0);
		chk(32'(pb_oe_n), 32'h0000002C);
		chk(32'(pb_out[4]), 32'h00000000);
		chk(32'(pb_pu), 32'h0000002C);
		pb_xe <= 6'h04;
		tick(3);
		chk(32'({ss_n_i, sck_i, mosi_i}), 32'h00000003);
		@(posedge hclk);
		spi_mst <= 1'b1;
		sck_o <= 1'b0;
		tick(3);
		chk(32'(pb_oe_n), 32'h00000010);
		chk(32'(pb_out[5]), 32'h00000000);
		chk(32'({pb_pu, miso_i}), 32'h00000021);
		@(posedge hclk);
		pb_xe <= 6'h00;
		spi_en <= 1'b0;
	endtask

	task automatic t_timer();
		wr(mpp_pkg::IDX_B_DIR, 32'h00000002);
		@(posedge hclk);
		cmp_en <= 1'b1;
		cmp_o <= 1'b0;
		tick(2);
		chk(32'({pb_oe_n[1], pb_out[1], cap_i}), 32'h00000001);
		pb_xe <= 6'h01;
		tick(3);
		chk(32'(cap_i), 32'h00000000);
	endtask

	task automatic t_uart();
		wr(mpp_pkg::IDX_D_DIR, 32'h00000001);
		wr(mpp_pkg::IDX_D_LATCH, 32'h00000001);
		@(posedge hclk);
		tx_en <= 1'b1;
		txd <= 1'b1;
		rx_en <= 1'b1;
		tick(2);
		chk(32'({pd_oe_n[1:0], pd_out[1], pd_pu[0], rxd_i}), 32'h0000000F);
		pd_xe <= 8'h01;
		tick(3);
		chk(32'(rxd_i), 32'h00000000);
	endtask

	task automatic t_mid_reset();
		wr(mpp_pkg::IDX_C_DIR, 32'h0000003F);
		chk(32'({pc_oe_n, pc_out, pc_pu}), 32'h00000FC0);
		@(posedge hclk);
		hresetn <= 1'b0;
		{tx_en, rx_en, cmp_en, pd_xe, pb_xe} <= '0;
		#1;
		chk(32'({pb_oe_n, pc_oe_n, pd_oe_n}), 32'h000FFFFF);
		chk(32'({pb_pu, pc_pu, pd_pu}), 32'h00000000);
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs_zero();
	endtask

	task automatic conclude();
		if (miscompares == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		#200us;
		miscompares++;
		$display("BAD %0t: run timed out", $time);
		conclude();
	end

	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata, pb_xe, pb_xv, pd_xe, pd_xv} = '0;
		{spi_en, spi_mst, sck_o, mosi_o, miso_o, cmp_en, cmp_o, tx_en, txd, rx_en, pdown} = '0;
		hsize = 3'b010;
		miscompares = 0;
		cmp_count = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs_zero();
		t_gpio();
		t_narrow();
		t_spi();
		t_timer();
		t_uart();
		t_mid_reset();
		conclude();
	end
endmodule // test_multi_port_pin_control
